// [rtl/microcore_mode_set_decoder.sv]
// mode-set instruction decoder of one microcore, with the alu result
// conditioning, automatic dc-dc regulation and dac slice steering it drives
// assumes instructions arrive with a one-cycle execute strobe on ref_clk,
// and software reaches the mode and control registers over apb
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - arithmetic-mode opcode recognised by upper bits; two low bits latched
// - codes: signed wrap, signed saturate, unsigned wrap, unsigned saturate
// - mode held in arith_mode_hi_bit/lo_bit, updated on each execution
// - wrapping modes flag overflow and keep the wrapped result
// - saturating modes flag overflow and clamp to representable limit
// - arithmetic mode resets to unsigned wrap, code 10
// - control-bit instruction: level bit 4, zero bit 3, selector bits 2..0
// - only the selected control register bit 8..15 takes the level
// - each microcore may read another microcore's shared register
// - shared-register select instruction latches a two-bit target
// - targets: self, other same channel, same other channel, other other
// - dc-dc instruction bit 0; value 0 leaves low-side 7 to microcore
// - value 1 regulates current via low-side 7 between block 4 thresholds
// - dc-dc control resets to microcore mode
// - dac access instruction latches a two-bit slice mode
// - value mode moves dac or high threshold in low 8 bits
// - offset mode uses bits 13..8; negative threshold bits 11..8
// - full mode moves both slices together
// - boost mode: dac address reaches nothing, threshold gets boost value
// - dac access mode resets to value slice, code 01
module microcore_mode_set_decoder
   import mode_set_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // instruction from the sequencer
   input wire logic instrValid,
   input wire logic [15:0] instrWord,
   // alu add or subtract request
   input wire logic aluReq,
   input wire logic aluSub,
   input wire logic [15:0] aluOpA,
   input wire logic [15:0] aluOpB,
   // dc-dc low-side 7 drive
   input wire logic ls7MicroCmd,
   input wire logic curBelowLow,
   input wire logic curAboveHigh,
   // data memory access to dac addresses
   input wire logic memReq,
   input wire logic memWrite,
   input wire logic memDacAddr,
   input wire logic memThreshAddr,
   input wire logic [15:0] memWdata,
   input wire logic [7:0] dacValue,
   input wire logic [5:0] dacOffset,
   input wire logic [7:0] highThrValue,
   input wire logic [3:0] negThrValue,
   input wire logic [7:0] boostValue,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // mode outputs
   output logic [1:0] arithMode,
   output logic [7:0] ctrlRegHi,
   output logic [1:0] commTarget,
   output logic dcdcMode,
   output logic [1:0] dacMode,
   // alu result
   output logic [15:0] aluResult,
   output logic aluOverflow,
   output logic aluDone,
   // low-side 7 gate
   output logic ls7Gate,
   // dac slice access
   output logic [15:0] memRdata,
   output logic memRvalid,
   output logic [15:0] dacWrData,
   output logic wrLoSlice,
   output logic wrHiSlice,
   output logic wrBoost
);

   typedef struct packed {
      logic [1:0] arith;
      logic [7:0] ctrlHi;
      logic [1:0] tgt;
      logic dcdc;
      logic [1:0] dac;
      logic [15:0] aluRes;
      logic aluOvf;
      logic aluDone;
      logic ls7;
      logic [15:0] rdata;
      logic rvalid;
      logic [15:0] wdata;
      logic wrLo;
      logic wrHi;
      logic wrBst;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } state_s;

   state_s st_r;
   state_s st_nxt;

   logic isArith;
   logic isCtrlBit;
   logic isComm;
   logic isDcdc;
   logic isDac;
   logic apbAccess;
   logic apbDone;
   logic [16:0] rawSum;
   logic sgnOvf;
   logic unsOvf;

   // instruction decode on fixed opcode bits
   assign isArith = instrValid
      && ((instrWord & MASK_ARITH) == OP_ARITH);
   assign isCtrlBit = instrValid
      && ((instrWord & MASK_CTRLBIT) == OP_CTRLBIT);
   assign isComm = instrValid
      && ((instrWord & MASK_COMM) == OP_COMM);
   assign isDcdc = instrValid
      && ((instrWord & MASK_DCDC) == OP_DCDC);
   assign isDac = instrValid
      && ((instrWord & MASK_DAC) == OP_DAC);

   assign apbAccess = psel && penable;
   assign apbDone = apbAccess && st_r.pready;

   // 17-bit raw result; signed view uses sign extension
   always_comb begin
      logic [16:0] a17;
      logic [16:0] b17;
      a17 = '0;
      b17 = '0;
      if (st_r.arith[1]) begin
         a17 = {1'b0, aluOpA};
         b17 = {1'b0, aluOpB};
      end else begin
         a17 = {aluOpA[15], aluOpA};
         b17 = {aluOpB[15], aluOpB};
      end
      if (aluSub) begin
         rawSum = a17 - b17;
      end else begin
         rawSum = a17 + b17;
      end
   end

   assign sgnOvf = rawSum[16] != rawSum[15];
   assign unsOvf = rawSum[16];

   always_comb begin
      st_nxt = st_r;
      st_nxt.aluDone = 1'b0;
      st_nxt.rvalid = 1'b0;
      st_nxt.wrLo = 1'b0;
      st_nxt.wrHi = 1'b0;
      st_nxt.wrBst = 1'b0;
      st_nxt.pslverr = 1'b0;

      // apb: one wait state, then the access completes
      st_nxt.pready = apbAccess && !st_r.pready;
      if (apbAccess && !st_r.pready) begin
         unique case (paddr)
            REG_MODE: begin
               st_nxt.prdata = '0;
               st_nxt.prdata[MS_ARITH_POS +: 2] = st_r.arith;
               st_nxt.prdata[MS_TGT_POS +: 2] = st_r.tgt;
               st_nxt.prdata[MS_DCDC_POS] = st_r.dcdc;
               st_nxt.prdata[MS_DAC_POS +: 2] = st_r.dac;
               st_nxt.prdata[MS_LS7_POS] = st_r.ls7;
               st_nxt.prdata[MS_OVF_POS] = st_r.aluOvf;
            end
            REG_CTRL: begin
               st_nxt.prdata = {16'h0000, st_r.ctrlHi, 8'h00};
            end
            default: begin
               st_nxt.prdata = '0;
               st_nxt.pslverr = 1'b1;
            end
         endcase
      end else if (apbDone) begin
         st_nxt.prdata = '0;
      end
      if (apbDone && pwrite && paddr == REG_CTRL) begin
         st_nxt.ctrlHi = pwdata[15:8];
      end

      // mode-setting instructions; instruction bit write wins over apb
      if (isArith) begin
         st_nxt.arith = instrWord[1:0];
      end
      if (isCtrlBit) begin
         st_nxt.ctrlHi[instrWord[2:0]] = instrWord[CB_LEVEL_POS];
      end
      if (isComm) begin
         st_nxt.tgt = instrWord[1:0];
      end
      if (isDcdc) begin
         st_nxt.dcdc = instrWord[0];
      end
      if (isDac) begin
         st_nxt.dac = instrWord[1:0];
      end

      // alu result conditioning by the current mode
      if (aluReq) begin
         st_nxt.aluDone = 1'b1;
         st_nxt.aluRes = rawSum[15:0];
         unique case (st_r.arith)
            SIGNED_WRAP: begin
               st_nxt.aluOvf = sgnOvf;
            end
            SIGNED_SAT: begin
               st_nxt.aluOvf = sgnOvf;
               if (sgnOvf) begin
                  st_nxt.aluRes = rawSum[16] ? 16'h8000 : 16'h7FFF;
               end
            end
            UNSIGNED_WRAP: begin
               st_nxt.aluOvf = unsOvf;
            end
            UNSIGNED_SAT: begin
               st_nxt.aluOvf = unsOvf;
               if (unsOvf) begin
                  st_nxt.aluRes = aluSub ? 16'h0000 : 16'hFFFF;
               end
            end
         endcase
      end

      // low-side 7: follow the microcore or regulate by hysteresis
      if (st_r.dcdc == DCDC_MICRO) begin
         st_nxt.ls7 = ls7MicroCmd;
      end else if (curAboveHigh) begin
         st_nxt.ls7 = 1'b0;
      end else if (curBelowLow) begin
         st_nxt.ls7 = 1'b1;
      end

      // dac data memory slice steering
      if (memReq && (memDacAddr || memThreshAddr)) begin
         st_nxt.rvalid = !memWrite;
         st_nxt.wdata = memWdata;
         st_nxt.rdata = '0;
         unique case (st_r.dac)
            DAC_BOOST: begin
               if (memThreshAddr) begin
                  st_nxt.rdata = {8'h00, boostValue};
                  st_nxt.wrBst = memWrite;
               end
            end
            DAC_VALUE: begin
               st_nxt.rdata[7:0] = memDacAddr ? dacValue
                  : highThrValue;
               st_nxt.wrLo = memWrite;
            end
            DAC_OFFSET: begin
               if (memDacAddr) begin
                  st_nxt.rdata[13:8] = dacOffset;
               end else begin
                  st_nxt.rdata[11:8] = negThrValue;
               end
               st_nxt.wrHi = memWrite;
            end
            DAC_FULL: begin
               if (memDacAddr) begin
                  st_nxt.rdata = {2'h0, dacOffset, dacValue};
               end else begin
                  st_nxt.rdata = {4'h0, negThrValue,
                     highThrValue};
               end
               st_nxt.wrLo = memWrite;
               st_nxt.wrHi = memWrite;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_r <= '0;
         st_r.arith <= ARITH_RST;
         st_r.ctrlHi <= CTRL_HI_RST;
         st_r.tgt <= TGT_RST;
         st_r.dcdc <= DCDC_RST;
         st_r.dac <= DAC_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign arithMode = st_r.arith;
   assign ctrlRegHi = st_r.ctrlHi;
   assign commTarget = st_r.tgt;
   assign dcdcMode = st_r.dcdc;
   assign dacMode = st_r.dac;
   assign aluResult = st_r.aluRes;
   assign aluOverflow = st_r.aluOvf;
   assign aluDone = st_r.aluDone;
   assign ls7Gate = st_r.ls7;
   assign memRdata = st_r.rdata;
   assign memRvalid = st_r.rvalid;
   assign dacWrData = st_r.wdata;
   assign wrLoSlice = st_r.wrLo;
   assign wrHiSlice = st_r.wrHi;
   assign wrBoost = st_r.wrBst;
   assign pready = st_r.pready;
   assign prdata = st_r.prdata;
   assign pslverr = st_r.pslverr;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   arith_latch_a: assert property (
      isArith |=> arithMode == $past(instrWord[1:0]))
      else $error("arithmetic mode not latched");

   arith_reset_a: assert property (
      $fell(reset) |-> arithMode == UNSIGNED_WRAP && dacMode == DAC_VALUE
         && dcdcMode == DCDC_MICRO && commTarget == TGT_SELF)
      else $error("modes wrong after reset");

   mode_hold_a: assert property (
      !instrValid |=> $stable(arithMode) && $stable(commTarget)
         && $stable(dacMode) && $stable(dcdcMode))
      else $error("mode changed without instruction");

   ctrl_bit_a: assert property (
      isCtrlBit |=> ctrlRegHi[$past(instrWord[2:0])]
         == $past(instrWord[CB_LEVEL_POS]))
      else $error("control bit not written");

   signed_sat_a: assert property (
      aluReq && arithMode == SIGNED_SAT && sgnOvf && !rawSum[16]
         |=> aluOverflow && aluResult == 16'h7FFF)
      else $error("signed saturation wrong");

   wrap_keep_a: assert property (
      aluReq && !arithMode[0] |=> aluResult == $past(rawSum[15:0]))
      else $error("wrapping result altered");

   ls7_auto_a: assert property (
      dcdcMode == DCDC_AUTO && curAboveHigh ##1 dcdcMode == DCDC_AUTO
         |-> !ls7Gate)
      else $error("low-side 7 not released above high threshold");

   boost_null_a: assert property (
      memReq && memDacAddr && dacMode == DAC_BOOST
         |=> memRdata == 16'h0000 && !wrLoSlice && !wrHiSlice)
      else $error("boost mode reached dac register");

   offset_slice_a: assert property (
      memReq && memDacAddr && !memWrite && dacMode == DAC_OFFSET
         |=> memRdata == {2'h0, $past(dacOffset), 8'h00})
      else $error("offset slice misplaced");

   apb_wait_a: assert property (
      psel && penable && !pready |=> pready ##1 !pready)
      else $error("apb answer timing wrong");

endmodule : microcore_mode_set_decoder

`default_nettype wire

// [rtl/mode_set_pkg.sv]
// constants for the microcore mode-set instruction decoder
// assumes 16-bit instruction words and a 32-bit apb register port
package mode_set_pkg;
   // opcode match values and masks
   localparam logic [15:0] OP_ARITH = 16'h357C;
   localparam logic [15:0] MASK_ARITH = 16'hFFFC;
   localparam logic [15:0] OP_CTRLBIT = 16'h3740;
   localparam logic [15:0] MASK_CTRLBIT = 16'hFFE8;
   localparam logic [15:0] OP_COMM = 16'h358C;
   localparam logic [15:0] MASK_COMM = 16'hFFFC;
   localparam logic [15:0] OP_DCDC = 16'h3542;
   localparam logic [15:0] MASK_DCDC = 16'hFFFE;
   localparam logic [15:0] OP_DAC = 16'h3584;
   localparam logic [15:0] MASK_DAC = 16'hFFFC;
   // operand field positions
   localparam int CB_LEVEL_POS = 4;
   // arithmetic modes
   localparam logic [1:0] SIGNED_WRAP = 2'h0;
   localparam logic [1:0] SIGNED_SAT = 2'h1;
   localparam logic [1:0] UNSIGNED_WRAP = 2'h2;
   localparam logic [1:0] UNSIGNED_SAT = 2'h3;
   // shared register targets
   localparam logic [1:0] TGT_SELF = 2'h0;
   // dc-dc control modes
   localparam logic DCDC_MICRO = 1'b0;
   localparam logic DCDC_AUTO = 1'b1;
   // dac access modes
   localparam logic [1:0] DAC_BOOST = 2'h0;
   localparam logic [1:0] DAC_VALUE = 2'h1;
   localparam logic [1:0] DAC_OFFSET = 2'h2;
   localparam logic [1:0] DAC_FULL = 2'h3;
   // reset values
   localparam logic [1:0] ARITH_RST = UNSIGNED_WRAP;
   localparam logic [1:0] TGT_RST = TGT_SELF;
   localparam logic DCDC_RST = DCDC_MICRO;
   localparam logic [1:0] DAC_RST = DAC_VALUE;
   localparam logic [7:0] CTRL_HI_RST = 8'h00;
   // apb register byte addresses
   localparam logic [11:0] REG_MODE = 12'h000;
   localparam logic [11:0] REG_CTRL = 12'h004;
   // mode status register field positions
   localparam int MS_ARITH_POS = 0;
   localparam int MS_TGT_POS = 2;
   localparam int MS_DCDC_POS = 4;
   localparam int MS_DAC_POS = 5;
   localparam int MS_LS7_POS = 7;
   localparam int MS_OVF_POS = 8;
endpackage : mode_set_pkg

// [test/mode_seq_model.sv]
// sequencer model: hands single instruction words to the decoder
// assumes the decoder takes a word on the edge where the strobe is high
`timescale 1ns/1ps
`default_nettype none
module mode_seq_model (
   // clock
   input wire logic ref_clk,
   // instruction strobe and word
   output logic instrValid,
   output logic [15:0] instrWord
);
   initial begin
      instrValid = 1'b0;
      instrWord = 16'hFFFF;
   end
   // one-cycle strobe; the released word shows its inverse
   task issue(input logic [15:0] w);
      @(posedge ref_clk);
      instrValid <= 1'b1;
      instrWord <= w;
      @(posedge ref_clk);
      instrValid <= 1'b0;
      instrWord <= ~w;
   endtask : issue
endmodule : mode_seq_model
`default_nettype wire

// [test/tb_microcore_mode_set_decoder.sv]
// self-checking bench of the mode-set decoder against a behavioural model
// assumes the sequencer model and the design package are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_microcore_mode_set_decoder;
   import mode_set_pkg::*;
   logic ref_clk, reset, instrValid, aluReq, aluSub, ls7MicroCmd;
   logic curBelowLow, curAboveHigh, memReq, memWrite, memDacAddr;
   logic memThreshAddr, psel, penable, pwrite, pready, pslverr;
   logic aluOverflow, aluDone, dcdcMode, ls7Gate, memRvalid;
   logic wrLoSlice, wrHiSlice, wrBoost, e, ov;
   logic [15:0] instrWord, aluOpA, aluOpB, memWdata, aluResult;
   logic [15:0] memRdata, dacWrData;
   logic [7:0] dacValue, highThrValue, boostValue, ctrlRegHi, cr;
   logic [5:0] dacOffset;
   logic [3:0] negThrValue;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rs, r;
   logic [1:0] arithMode, commTarget, dacMode;
   int am, ct, dm, dc, errors, numChecks;
   microcore_mode_set_decoder uut (.*);
   mode_seq_model seq (.ref_clk(ref_clk), .instrValid(instrValid),
      .instrWord(instrWord));
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task results;
      if (errors == 0 && numChecks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results
   task chk(input logic [31:0] g, input logic [31:0] x, input string m);
      numChecks++;
      if (g !== x) begin
         errors++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask : chk
   function logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? (s >> 1) ^ 32'hA3000000 : s >> 1;
   endfunction : lfsr
   // reference alu: {overflow, result}
   function logic [16:0] aref(input logic [1:0] m, input logic s,
      input logic [15:0] a, input logic [15:0] b);
      logic [16:0] q;
      logic o;
      q = s ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
      o = m[1] ? q[16] : (s ^ (a[15] == b[15])) && q[15] != a[15];
      if (o && m[0]) begin
         q[15:0] = m[1] ? {16{~s}} : (a[15] ? 16'h8000 : 16'h7FFF);
      end
      return {o, q[15:0]};
   endfunction : aref
   task rstchk;
      am = 2;
      ct = 0;
      dm = 1;
      dc = 0;
      cr = 8'h00;
      chk(arithMode, am, "arith reset");
      chk(ctrlRegHi, cr, "ctrl reset");
      chk(commTarget, ct, "target reset");
      chk(dcdcMode, dc, "dcdc reset");
      chk(dacMode, dm, "dac reset");
   endtask : rstchk
   task alu(input int i);
      logic [15:0] a, b;
      logic s;
      logic [16:0] x;
      rs = lfsr(rs);
      a = i == 0 ? 16'h7FFF : i == 1 ? 16'h0000 : rs[15:0];
      b = i < 2 ? 16'h0001 : rs[31:16];
      s = i == 0 ? 1'b0 : i == 1 ? 1'b1 : rs[7];
      x = aref(am[1:0], s, a, b);
      ov = x[16];
      @(posedge ref_clk);
      aluReq <= 1'b1;
      aluSub <= s;
      aluOpA <= a;
      aluOpB <= b;
      @(posedge ref_clk);
      aluReq <= 1'b0;
      @(negedge ref_clk);
      chk(aluDone, 1, "alu done");
      chk({aluOverflow, aluResult}, x, "alu result");
   endtask : alu
   task mem(input logic w, input logic t);
      rs = lfsr(rs);
      @(posedge ref_clk);
      memReq <= 1'b1;
      memWrite <= w;
      memDacAddr <= ~t;
      memThreshAddr <= t;
      memWdata <= rs[15:0];
      @(posedge ref_clk);
      memReq <= 1'b0;
      @(negedge ref_clk);
   endtask : mem
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      results();
   end
   initial begin
      {aluReq, aluSub, ls7MicroCmd, curBelowLow, curAboveHigh} = '0;
      {memReq, memWrite, memDacAddr, memThreshAddr, psel, penable} = '0;
      {pwrite, paddr, pwdata, aluOpA, aluOpB, memWdata} = '0;
      rs = 32'h6CFEDD97;
      {dacValue, highThrValue, boostValue} = rs[23:0];
      dacOffset = rs[29:24];
      negThrValue = rs[31:28];
      errors = 0;
      numChecks = 0;
      reset = 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      @(negedge ref_clk);
      rstchk();
      for (int m = 0; m < 4; m++) begin
         seq.issue(16'h357C | m[15:0]);
         am = m;
         seq.issue(16'h3578); // near miss is ignored
         @(negedge ref_clk);
         chk(arithMode, am, "arith mode");
         for (int i = 0; i < 6; i++) alu(i);
      end
      for (int k = 0; k < 8; k++) begin
         seq.issue(16'h3750 | k[15:0]);
         cr[k] = 1'b1;
         seq.issue(16'h3748 | k[15:0]); // bit 3 set: refused
         @(negedge ref_clk);
         chk(ctrlRegHi, cr, "ctrl bit set");
      end
      for (int k = 0; k < 8; k += 2) seq.issue(16'h3740 | k[15:0]);
      @(negedge ref_clk);
      chk(ctrlRegHi, 8'hAA, "ctrl bit clear");
      for (int t = 0; t < 4; t++) begin
         seq.issue(16'h358C | t[15:0]);
         ct = t;
         @(negedge ref_clk);
         chk(commTarget, ct, "target");
      end
      @(posedge ref_clk);
      ls7MicroCmd <= 1'b1;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(ls7Gate, 1, "ls7 micro");
      seq.issue(16'h3543);
      dc = 1;
      for (int k = 0; k < 4; k++) begin
         @(posedge ref_clk);
         {curAboveHigh, curBelowLow} <= 2'(12'h8CE >> (10 - 3 * k));
         repeat (2) @(posedge ref_clk);
         @(negedge ref_clk);
         chk(ls7Gate, 12'h8CE >> (9 - 3 * k) & 1, "ls7 auto");
      end
      seq.issue(16'h3542);
      dc = 0;
      ls7MicroCmd <= 1'b0;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(ls7Gate, 0, "ls7 back");
      for (int m = 0; m < 4; m++) begin
         seq.issue(16'h3584 | m[15:0]);
         dm = m;
         @(negedge ref_clk);
         chk(dacMode, dm, "dac mode");
         for (int t = 0; t < 2; t++) begin
            mem(1'b0, t[0]);
            chk(memRdata, t == 0 ? {2'h0, m[1] ? dacOffset : 6'h0,
               m[0] ? dacValue : 8'h0} : m == 0 ? {8'h0, boostValue} :
               {4'h0, m[1] ? negThrValue : 4'h0,
               m[0] ? highThrValue : 8'h0},
               "dac read");
            chk(memRvalid, 1, "read strobe");
            mem(1'b1, t[0]);
            chk({wrBoost, wrHiSlice, wrLoSlice}, m == 0 ? {t[0], 2'b00} :
               {1'b0, m[1:0]}, "dac lanes");
            chk(dacWrData, rs[15:0], "write data");
         end
      end
      apb(1'b1, 12'h004, 32'h0000A500);
      cr = 8'hA5;
      apb(1'b0, 12'h004, 32'h00000000);
      chk(r[15:8], cr, "ctrl read");
      apb(1'b1, 12'h000, 32'hFFFFFFFF);
      apb(1'b0, 12'h000, 32'h00000000);
      chk(r[8:0], {ov, 1'b0, dm[1:0], dc[0], ct[1:0], am[1:0]},
         "mode read");
      apb(1'b0, 12'h008, 32'h00000000);
      chk(r, 0, "unmapped data");
      chk(e, 1, "unmapped error");
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      @(negedge ref_clk);
      rstchk();
      results();
   end
endmodule : tb_microcore_mode_set_decoder
`default_nettype wire
